// File: verilog/rsc_repeater_core.sv
// Purpose: port and main state machines of a cascadable multiport repeater
// Assumes: ports deliver decoded NRZ bits; cascade pins are asynchronous
// Notes:   open-drain cascade lines are value, enable pairs; value is always low
`timescale 1ns/10ps
`include "rsc_map.svh"

// Operation
// - port machines gate data and jam onto segments
// - arbitrate single source port before leaving idle
// - source data to elasticity buffer and cascade bus
// - second arbitration in transmit collision picks last
// - one port left: last port muted, others transmit
// - regenerate preamble to full length
// - extend short fragments to 96 bits
// - control elasticity buffer for preamble regeneration
// - jam uses the alternating 1010 pattern
// - transmit collision lasts at least 96 bits
// - Manchester encode buffered NRZ data
// - enforce transmit recovery time
// - enforce carrier recovery on colliding ports
// - eight-line cascade bus joins chips
// - bus carries activity, data, collisions, disable
// - holder shows chain out low, in high, outside transmit collision
// - chain output from end of port chain
// - activity line driven by holder and by transmit collision winner
// - activity line is wired-OR
// - every chip monitors the activity line
// - port 1 highest, port 7 lowest priority
// - source is highest active port while idle
// - last port: highest colliding at collision exit
module rsc_repeater_core
  import rsc_pkg::*;
#(
  parameter int NP       = `RSC_NUM_PORTS,
  parameter int TW1_BITS = `RSC_TW1_BITS,
  parameter int TW2_BITS = `RSC_TW2_BITS,
  parameter int EB_DEPTH = 32
)
(
  // clock and reset
  input  wire logic          I_CLK,
  input  wire logic          I_RST,
  // segment side
  input  wire logic [NP-1:0] I_PORT_RX,
  input  wire logic [NP-1:0] I_PORT_COL,
  input  wire logic [NP-1:0] I_PORT_DATA,
  output logic      [NP-1:0] O_PORT_TX_EN,
  output logic               O_TX_MANCH,
  // arbitration chain
  input  wire logic          I_ARB_CHAIN_IN,
  output logic               O_ARB_CHAIN_OUT,
  // wired-or cascade status lines
  input  wire logic          I_SRC_PORT_ACT_N,
  output logic               O_SRC_PORT_ACT_N,
  output logic               O_SRC_PORT_ACT_OE,
  input  wire logic          I_SRC_COL_N,
  output logic               O_SRC_COL_N,
  output logic               O_SRC_COL_OE,
  input  wire logic          I_OTHER_COL_N,
  output logic               O_OTHER_COL_N,
  output logic               O_OTHER_COL_OE,
  // cascade data
  input  wire logic          I_CASC_EN,
  input  wire logic          I_CASC_DATA,
  output logic               O_CASC_EN,
  output logic               O_CASC_DATA,
  output logic               O_CASC_CLK,
  output logic               O_CASC_OE,
  // jabber protection
  input  wire logic          I_DISABLE_OUT_N
);
  localparam int         CW       = 4;
  localparam logic [CW-1:0] BIT_CYC = CW'(`RSC_BIT_NS / `RSC_CLK_NS);
  localparam logic [CW-1:0] HALF    = CW'(`RSC_BIT_NS / `RSC_CLK_NS / 2);
  localparam logic [15:0] PRE_B   = 16'(`RSC_PRE_BITS);
  localparam logic [15:0] FRAG_B  = 16'(`RSC_FRAG_BITS);
  localparam logic [15:0] TXCOL_B = 16'(`RSC_TXCOL_BITS);
  localparam logic [15:0] TW1_B   = 16'(TW1_BITS);
  localparam logic [15:0] TW2_B   = 16'(TW2_BITS);
  localparam logic [15:0] TWC_B   = (TW1_B > TW2_B) ? TW1_B : TW2_B;
  localparam int         NW       = $clog2(NP + 1);

  typedef struct packed
  {
    logic [NP-1:0]            rx1;
    logic [NP-1:0]            rx2;
    logic [NP-1:0]            col1;
    logic [NP-1:0]            col2;
    logic [NP-1:0]            dat1;
    logic [NP-1:0]            dat2;
    logic [`RSC_M_WIDTH-1:0]  m1;
    logic [`RSC_M_WIDTH-1:0]  m2;
    rsc_state_t               state;
    logic                     own;
    logic [NP-1:0]            sel;
    logic [CW-1:0]            cyc;
    logic [15:0]              bits;
    logic [15:0]              sent;
    logic                     pat;
    logic                     prev;
    logic                     sfd;
    logic                     had_col;
    logic                     cur;
    logic [NP-1:0]            tx_en;
    logic                     manch;
    logic                     aout;
    logic                     act_oe;
    logic                     scol_oe;
    logic                     ocol_oe;
    logic                     casc_en;
    logic                     casc_dat;
    logic                     casc_clk;
    logic                     casc_oe;
  } rsc_core_st_t;

  rsc_core_st_t st;
  rsc_core_st_t next_st;
  rsc_eb_if     eb ();

  // priority chain: lowest index wins, grant stops the chain below it
  function automatic logic [NP:0] arb_chain(input logic ack_in, input logic [NP-1:0] req);
    logic [NP-1:0] g;
    logic          ack;
    g   = '0;
    ack = ack_in;
    for (int i = 0; i < NP; i++)
    begin
      g[i] = ack & req[i];
      ack  = ack & ~req[i];
    end
    return {ack, g};
  endfunction

  function automatic logic [NW-1:0] ones(input logic [NP-1:0] v);
    logic [NW-1:0] n;
    n = '0;
    for (int i = 0; i < NP; i++)
      n = n + NW'(v[i]);
    return n;
  endfunction

  logic          tick;
  logic          ain;
  logic          act_low;
  logic          rcol;
  logic          ocol;
  logic          dis;
  logic [NP-1:0] held;
  logic [NP-1:0] req;
  logic [NP-1:0] grant;
  logic          chain_out;
  logic          src_en;
  logic          src_bit;
  logic          src_col;
  logic          loc_ocol;
  logic [NW-1:0] ncol;
  logic          xmit;
  logic          tx_any_col;

  always_comb
  begin
    next_st      = st;
    next_st.rx1  = I_PORT_RX;
    next_st.rx2  = st.rx1;
    next_st.col1 = I_PORT_COL;
    next_st.col2 = st.col1;
    next_st.dat1 = I_PORT_DATA;
    next_st.dat2 = st.dat1;
    next_st.m1   = {I_DISABLE_OUT_N, I_CASC_DATA, I_CASC_EN, I_OTHER_COL_N,
                    I_SRC_COL_N, I_SRC_PORT_ACT_N, I_ARB_CHAIN_IN};
    next_st.m2   = st.m1;

    tick    = (st.cyc == BIT_CYC - 1'b1);
    ain     = st.m2[`RSC_M_CHAIN_IN];
    act_low = !st.m2[`RSC_M_ACT_N];
    rcol    = !st.m2[`RSC_M_SCOL_N];
    ocol    = !st.m2[`RSC_M_OCOL_N];
    dis     = !st.m2[`RSC_M_DIS_N];
    held    = st.own ? st.sel : '0;
    // idle: receive or collision; transmit collision: collisions only
    if (st.state == S_IDLE)
      req = st.rx2 | st.col2;
    else if (st.state == S_TXCOL)
      req = st.col2;
    else
      req = held;
    {chain_out, grant} = arb_chain(ain, req);
    src_en   = st.own ? |(st.rx2 & st.sel) : st.m2[`RSC_M_CASC_EN];
    src_bit  = st.own ? |(st.dat2 & st.sel) : st.m2[`RSC_M_CASC_DAT];
    src_col  = st.own ? |(st.col2 & st.sel) : rcol;
    loc_ocol = |(st.col2 & ~held);
    ncol     = ones(st.col2);
    tx_any_col = loc_ocol || ocol;
    xmit     = !(st.state inside {S_IDLE, S_RECOVER});

    next_st.cyc  = tick ? '0 : st.cyc + 1'b1;
    next_st.aout = chain_out;

    eb.clear  = (st.state == S_IDLE);
    eb.wr_en  = tick && st.sfd && src_en && (st.state inside {S_PREAM, S_DATA});
    eb.wr_bit = src_bit;
    // head leaves as the last preamble bit ends, so data follows it directly
    eb.rd_en  = tick && ((st.state == S_DATA) ||
                         (st.state == S_PREAM && st.bits == PRE_B - 16'h0001));

    if (tick)
    begin
      next_st.pat  = ~st.pat;
      next_st.prev = src_bit;
      if (st.bits != 16'hFFFF)
        next_st.bits = st.bits + 16'h0001;
      if (xmit && st.sent != 16'hFFFF)
        next_st.sent = st.sent + 16'h0001;
      if (!st.sfd && src_en && st.prev && src_bit)
        next_st.sfd = 1'b1;
      next_st.cur = st.pat;
      case (st.state)
        S_IDLE:
        begin
          // first preamble bit is a one, no leading filler bit
          next_st.sent    = '0;
          next_st.pat     = 1'b0;
          next_st.sfd     = 1'b0;
          next_st.prev    = 1'b0;
          next_st.had_col = 1'b0;
          next_st.cur     = 1'b1;
          if (|grant)
          begin
            next_st.own   = 1'b1;
            next_st.sel   = grant;
            next_st.state = |(grant & st.col2) ? S_RXCOL : S_PREAM;
          end
          else if (act_low)
          begin
            next_st.own   = 1'b0;
            next_st.sel   = '0;
            next_st.state = rcol ? S_RXCOL : S_PREAM;
          end
        end
        S_PREAM:
        begin
          // 64th bit repeats the one before it to close the delimiter
          if (st.bits == PRE_B - 16'h0002)
            next_st.cur = 1'b1;
          else if (st.bits == PRE_B - 16'h0001 && !tx_any_col && !src_col)
            next_st.cur = eb.empty ? st.pat : eb.rd_bit;
          if (tx_any_col)
            next_st.state = S_TXCOL;
          else if (src_col)
            next_st.state = S_RXCOL;
          else if (st.bits == PRE_B - 1'b1)
            next_st.state = S_DATA;
          else if (!src_en && !st.sfd)
            next_st.state = S_EXTEND;
        end
        S_DATA:
        begin
          next_st.cur = eb.empty ? st.pat : eb.rd_bit;
          if (tx_any_col)
            next_st.state = S_TXCOL;
          else if (src_col)
            next_st.state = S_RXCOL;
          else if (eb.empty && !src_en)
            next_st.state = (st.sent >= FRAG_B) ? S_RECOVER : S_EXTEND;
        end
        S_EXTEND:
        begin
          if (tx_any_col)
            next_st.state = S_TXCOL;
          else if (st.sent >= FRAG_B - 1'b1)
            next_st.state = S_RECOVER;
        end
        S_RXCOL:
        begin
          next_st.had_col = 1'b1;
          if (loc_ocol && !st.own)
            next_st.state = S_TXCOL;
          else if (!src_col && !src_en && st.sent >= FRAG_B - 1'b1)
            next_st.state = S_RECOVER;
        end
        S_TXCOL:
        begin
          next_st.had_col = 1'b1;
          // a lower chip still colliding holds the line and keeps everyone here
          if (st.bits >= TXCOL_B - 1'b1 && !ocol && ncol <= NW'(1))
          begin
            if (|grant)
            begin
              next_st.own   = 1'b1;
              next_st.sel   = grant;
              next_st.state = S_ONELEFT;
            end
            else if (ncol == '0 && act_low)
            begin
              next_st.own   = 1'b0;
              next_st.sel   = '0;
              next_st.state = S_ONELEFT;
            end
            else if (ncol == '0)
              next_st.state = (st.sent >= FRAG_B - 1'b1) ? S_RECOVER : S_EXTEND;
          end
        end
        S_ONELEFT:
        begin
          if (loc_ocol || ocol)
            next_st.state = S_TXCOL;
          else if (st.own ? !(|(st.col2 & st.sel)) : !act_low)
            next_st.state = S_RECOVER;
        end
        S_RECOVER:
        begin
          // colliding ports also need carrier recovery before rearming
          if (st.bits >= (st.had_col ? TWC_B : TW1_B) - 1'b1)
          begin
            next_st.state = S_IDLE;
            next_st.own   = 1'b0;
            next_st.sel   = '0;
          end
        end
        default:
        begin
          next_st.state = S_IDLE;
          next_st.own   = 1'b0;
          next_st.sel   = '0;
        end
      endcase
      if (next_st.state != st.state)
        next_st.bits = '0;
    end

    // the source port hears only the jam of a transmit collision; last port is muted
    next_st.tx_en = '0;
    if (xmit && !dis)
    begin
      if (st.state == S_TXCOL)
        next_st.tx_en = '1;
      else
        next_st.tx_en = ~held;
    end
    next_st.manch = xmit ? ((st.cyc < HALF) ? ~st.cur : st.cur) : 1'b0;

    next_st.act_oe  = (st.own && xmit && (src_en || src_col))
                      || (st.state == S_TXCOL && |grant);
    next_st.scol_oe = st.own && xmit && src_col;
    if (st.state == S_TXCOL)
      next_st.ocol_oe = (ncol >= NW'(2)) || (ncol == NW'(1) && !ain);
    else
      next_st.ocol_oe = xmit && loc_ocol;
    next_st.casc_oe  = st.own && xmit;
    next_st.casc_en  = st.own && xmit && src_en;
    next_st.casc_dat = src_bit;
    next_st.casc_clk = (st.cyc >= HALF);
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      st       <= '0;
      st.state <= S_IDLE;
      st.pat   <= 1'b1;
    end
    else
      st <= next_st;
  end

  rsc_elastic_buf #(
    .DEPTH (EB_DEPTH)
  ) u_eb (
    .I_CLK (I_CLK),
    .I_RST (I_RST),
    .eb    (eb.store)
  );

  assign O_PORT_TX_EN      = st.tx_en;
  assign O_TX_MANCH        = st.manch;
  assign O_ARB_CHAIN_OUT   = st.aout;
  assign O_SRC_PORT_ACT_N  = 1'b0;
  assign O_SRC_PORT_ACT_OE = st.act_oe;
  assign O_SRC_COL_N       = 1'b0;
  assign O_SRC_COL_OE      = st.scol_oe;
  assign O_OTHER_COL_N     = 1'b0;
  assign O_OTHER_COL_OE    = st.ocol_oe;
  assign O_CASC_EN         = st.casc_en;
  assign O_CASC_DATA       = st.casc_dat;
  assign O_CASC_CLK        = st.casc_clk;
  assign O_CASC_OE         = st.casc_oe;

  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  txcol_min_a : assert property ((st.state == S_TXCOL && next_st.state != S_TXCOL)
    |-> st.bits >= TXCOL_B - 1'b1)
    else $error("transmit collision left too early");
  frag_min_a : assert property ((xmit && next_st.state == S_RECOVER)
    |-> st.sent >= FRAG_B - 1'b1)
    else $error("fragment shorter than minimum");
  pre_len_a : assert property ((st.state == S_PREAM && next_st.state == S_DATA)
    |-> st.bits == PRE_B - 1'b1)
    else $error("preamble not full length");
  mute_last_a : assert property ((st.state == S_ONELEFT && st.own)
    |=> (O_PORT_TX_EN & $past(st.sel)) == '0 && (O_PORT_TX_EN != '0 || $past(dis)))
    else $error("last port transmitting in one port left");
  chain_hold_a : assert property ((st.own && ain && xmit && st.state != S_TXCOL)
    |=> !O_ARB_CHAIN_OUT)
    else $error("holder chain output not low");
  chain_pass_a : assert property ((st.state == S_IDLE && (st.rx2 | st.col2) == '0)
    |=> O_ARB_CHAIN_OUT == $past(ain))
    else $error("idle chain input not passed through");
  act_holder_a : assert property (O_SRC_PORT_ACT_OE
    |-> $past(st.own) || $past(st.state == S_TXCOL))
    else $error("activity driven by non-holder");
  sel_onehot_a : assert property ((st.own && st.state != S_IDLE)
    |-> $onehot(st.sel))
    else $error("source port not unique");
  manch_mid_a : assert property ((st.cyc == HALF && xmit)
    |=> O_TX_MANCH != $past(O_TX_MANCH))
    else $error("no mid-bit transition");
  recover_a : assert property ((st.state == S_RECOVER && next_st.state == S_IDLE)
    |-> st.bits >= TW1_B - 1'b1)
    else $error("transmit recovery cut short");
endmodule

// File: verilog/rsc_map.svh
// Purpose: offsets, bit positions and timing counts of the repeater core
// Assumes: network bit rate of 10 Mb/s, core clock of 100 MHz
// Notes:   counts are in network bit times unless the name says NS
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH

`define RSC_CLK_NS      10
`define RSC_BIT_NS      100
`define RSC_PRE_BITS    64
`define RSC_FRAG_BITS   96
`define RSC_TXCOL_BITS  96
`define RSC_TW1_BITS    96
`define RSC_TW2_BITS    96
`define RSC_NUM_PORTS   7

// positions inside the synchronised cascade input vector
`define RSC_M_CHAIN_IN  0
`define RSC_M_ACT_N     1
`define RSC_M_SCOL_N    2
`define RSC_M_OCOL_N    3
`define RSC_M_CASC_EN   4
`define RSC_M_CASC_DAT  5
`define RSC_M_DIS_N     6
`define RSC_M_WIDTH     7

`endif

// File: verilog/rsc_pkg.sv
// Purpose: shared types of the repeater core
// Assumes: nothing beyond the map header
// Notes:   one-hot state codes are written out
package rsc_pkg;

  typedef enum logic [7:0]
  {
    S_IDLE    = 8'h01,
    S_PREAM   = 8'h02,
    S_DATA    = 8'h04,
    S_EXTEND  = 8'h08,
    S_RXCOL   = 8'h10,
    S_TXCOL   = 8'h20,
    S_ONELEFT = 8'h40,
    S_RECOVER = 8'h80
  } rsc_state_t;

endpackage

// File: verilog/rsc_eb_if.sv
// Purpose: carrier between main state machine and elasticity buffer
// Assumes: single clock domain
// Notes:   bit-serial, one bit per strobe
`timescale 1ns/10ps
interface rsc_eb_if;
  logic clear;
  logic wr_en;
  logic wr_bit;
  logic rd_en;
  logic rd_bit;
  logic empty;
  logic full;

  modport ctrl
  (
    output clear,
    output wr_en,
    output wr_bit,
    output rd_en,
    input  rd_bit,
    input  empty,
    input  full
  );

  modport store
  (
    input  clear,
    input  wr_en,
    input  wr_bit,
    input  rd_en,
    output rd_bit,
    output empty,
    output full
  );
endinterface

// File: verilog/rsc_elastic_buf.sv
// Purpose: bit-serial elasticity buffer holding received data
// Assumes: writes ignored when full, reads ignored when empty
// Notes:   read bit is combinational from the head of the store
`timescale 1ns/10ps
module rsc_elastic_buf
  import rsc_pkg::*;
#(
  parameter int DEPTH = 32
)
(
  // clock and reset
  input  wire logic   I_CLK,
  input  wire logic   I_RST,
  // buffer port
  rsc_eb_if.store     eb
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } rsc_eb_st_t;

  rsc_eb_st_t st;
  rsc_eb_st_t next_st;
  logic       mem [DEPTH];
  logic       do_wr;
  logic       do_rd;

  always_comb
  begin
    next_st = st;
    do_wr   = eb.wr_en && !eb.full;
    do_rd   = eb.rd_en && !eb.empty;
    if (eb.clear)
    begin
      next_st.wptr = '0;
      next_st.rptr = '0;
    end
    else
    begin
      if (do_wr)
        next_st.wptr = st.wptr + 1'b1;
      if (do_rd)
        next_st.rptr = st.rptr + 1'b1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
      st <= '0;
    else
      st <= next_st;
  end

  // storage needs no reset; pointers define what is valid
  always_ff @(posedge I_CLK)
  begin
    if (do_wr && !eb.clear)
      mem[st.wptr[AW-1:0]] <= eb.wr_bit;
  end

  assign eb.empty  = (st.wptr == st.rptr);
  assign eb.full   = (st.wptr[AW] != st.rptr[AW]) && (st.wptr[AW-1:0] == st.rptr[AW-1:0]);
  assign eb.rd_bit = mem[st.rptr[AW-1:0]];

  eb_fill_a : assert property (@(posedge I_CLK) disable iff (I_RST)
    (eb.wr_en && !eb.rd_en && !eb.clear && !eb.full) |=> !eb.empty)
    else $error("elasticity buffer lost a written bit");
endmodule

// File: bench/rsc_casc_partner.sv
// Purpose: stand-in for the other chips and pull-ups on the cascade bus
// Assumes: open-drain lines idle high through pull-ups
// Notes:   undriven data line inverts its last level so stale data never passes
`timescale 1ns/10ps
module rsc_casc_partner
(
  // clock
  input  wire logic i_clk,
  // bench commands
  input  wire logic i_upper_win,
  input  wire logic i_act,
  input  wire logic i_jabber,
  // core drives
  input  wire logic i_act_oe,
  input  wire logic i_scol_oe,
  input  wire logic i_ocol_oe,
  input  wire logic i_casc_oe,
  input  wire logic i_casc_en,
  input  wire logic i_casc_data,
  // wire levels seen by the core
  output logic      o_chain_in,
  output logic      o_act_n,
  output logic      o_scol_n,
  output logic      o_ocol_n,
  output logic      o_casc_en,
  output logic      o_casc_data,
  output logic      o_dis_n
);
  logic last = 1'b0;

  always @(posedge i_clk)
  begin
    if (i_casc_oe)
      last <= i_casc_data;
  end

  // top of chain stays high unless a chip above holds the grant
  assign o_chain_in  = ~i_upper_win;
  assign o_act_n     = ~(i_act_oe | i_act);
  assign o_scol_n    = ~i_scol_oe;
  assign o_ocol_n    = ~i_ocol_oe;
  // enable rests low between frames, data inverts while nobody drives it
  assign o_casc_en   = i_casc_oe ? i_casc_en : i_act;
  assign o_casc_data = i_casc_oe ? i_casc_data : ~last;
  assign o_dis_n     = ~i_jabber;
endmodule

// File: bench/tb_repeater_state_control.sv
// Purpose: self-checking bench of the repeater core
// Assumes: port inputs settle through two sync flops, bit tick every 10 cycles
// Notes:   recovery counts shortened to 4 bits to keep the run brief
`timescale 1ns/10ps
module tb_repeater_state_control;
  localparam int TW = 4;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [6:0] rx = 7'h00;
  logic [6:0] col = 7'h00;
  logic [7:0] dcnt = 8'h00;
  logic [2:0] dhist = 3'h0;
  logic       upper_win = 1'b0;
  logic       act = 1'b0;
  logic       jabber = 1'b0;
  logic [6:0] tx_en;
  logic       manch, chain_in, chain_out, act_in, act_out, act_oe;
  logic       scol_in, scol_out, scol_oe, ocol_in, ocol_out, ocol_oe;
  logic       cen_in, cdat_in, cen_out, cdat_out, cclk, casc_oe, dis_n;
  int         n_errors = 0;
  int         tests_run = 0;

  always #5 clk = ~clk;
  // received bits run in ones and twos so a delimiter is eventually seen
  always @(posedge clk) dcnt <= dcnt + 8'h01;
  // port data as the cascade data pin shows it, three edges late
  always @(posedge clk) dhist <= {dhist[1:0], dcnt[4]};

  rsc_repeater_core #(.NP(7), .TW1_BITS(TW), .TW2_BITS(TW), .EB_DEPTH(32)) dut
  (
    .I_CLK(clk), .I_RST(rst), .I_PORT_RX(rx), .I_PORT_COL(col),
    .I_PORT_DATA({7{dcnt[4]}}), .O_PORT_TX_EN(tx_en), .O_TX_MANCH(manch),
    .I_ARB_CHAIN_IN(chain_in), .O_ARB_CHAIN_OUT(chain_out),
    .I_SRC_PORT_ACT_N(act_in), .O_SRC_PORT_ACT_N(act_out), .O_SRC_PORT_ACT_OE(act_oe),
    .I_SRC_COL_N(scol_in), .O_SRC_COL_N(scol_out), .O_SRC_COL_OE(scol_oe),
    .I_OTHER_COL_N(ocol_in), .O_OTHER_COL_N(ocol_out), .O_OTHER_COL_OE(ocol_oe),
    .I_CASC_EN(cen_in), .I_CASC_DATA(cdat_in), .O_CASC_EN(cen_out),
    .O_CASC_DATA(cdat_out), .O_CASC_CLK(cclk), .O_CASC_OE(casc_oe),
    .I_DISABLE_OUT_N(dis_n)
  );

  rsc_casc_partner peer
  (
    .i_clk(clk), .i_upper_win(upper_win), .i_act(act), .i_jabber(jabber),
    .i_act_oe(act_oe), .i_scol_oe(scol_oe), .i_ocol_oe(ocol_oe), .i_casc_oe(casc_oe),
    .i_casc_en(cen_out), .i_casc_data(cdat_out), .o_chain_in(chain_in),
    .o_act_n(act_in), .o_scol_n(scol_in), .o_ocol_n(ocol_in), .o_casc_en(cen_in),
    .o_casc_data(cdat_in), .o_dis_n(dis_n)
  );

  task automatic results();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_vec({6'h00, got}, {6'h00, exp});
  endtask

  task automatic chk_min(input int got, input int lim);
    tests_run++;
    if (got < lim)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, lim);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // waits for the enable vector, returns cycles spent; a hang ends the run
  task automatic wait_tx(input logic [6:0] exp, output int n);
    n = 0;
    #1;
    while (tx_en !== exp)
    begin
      if (n == 4000)
      begin
        n_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, tx_en, exp);
        results();
      end
      cyc(1);
      n++;
    end
  endtask

  task automatic t_source();
    int n;
    logic hi;
    logic lo;
    @(posedge clk) rx <= 7'h04;
    wait_tx(7'h7B, n);
    chk_bit(act_oe, 1'b1);
    chk_bit(chain_out, 1'b0);
    chk_bit(casc_oe, 1'b1);
    chk_bit(cen_out, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      cyc(2);
      lo = manch;
      chk_bit(cclk, 1'b0);
      cyc(5);
      hi = manch;
      chk_bit(cclk, 1'b1);
      chk_bit(cdat_out, dhist[2]);
      chk_bit(hi, ~i[0]);
      chk_bit(lo, i[0]);
      cyc(3);
    end
    @(posedge clk) rx <= 7'h00;
    wait_tx(7'h00, n);
    chk_min(n + 81, 960);
    @(posedge clk) rx <= 7'h04;
    wait_tx(7'h7B, n);
    chk_min(n, TW * 10);
    @(posedge clk) rx <= 7'h00;
    wait_tx(7'h00, n);
    cyc(200);
  endtask

  task automatic t_priority();
    int n;
    @(posedge clk) rx <= 7'h12;
    wait_tx(7'h7D, n);
    @(posedge clk) col <= 7'h02;
    cyc(20);
    chk_bit(scol_oe, 1'b1);
    chk_vec(tx_en, 7'h7D);
    @(posedge clk)
    begin
      col <= 7'h00;
      rx <= 7'h00;
    end
    wait_tx(7'h00, n);
    cyc(200);
  endtask

  task automatic t_chain_low();
    int n;
    @(posedge clk)
    begin
      upper_win <= 1'b1;
      act <= 1'b1;
      rx <= 7'h01;
    end
    cyc(40);
    chk_vec(tx_en, 7'h7F);
    chk_bit(chain_out, 1'b0);
    chk_bit(act_oe, 1'b0);
    chk_bit(casc_oe, 1'b0);
    @(posedge clk)
    begin
      upper_win <= 1'b0;
      act <= 1'b0;
      rx <= 7'h00;
    end
    wait_tx(7'h00, n);
    cyc(300);
    chk_bit(chain_out, 1'b1);
  endtask

  task automatic t_jabber();
    int n;
    @(posedge clk) rx <= 7'h01;
    wait_tx(7'h7E, n);
    @(posedge clk) jabber <= 1'b1;
    cyc(5);
    chk_vec(tx_en, 7'h00);
    @(posedge clk) jabber <= 1'b0;
    wait_tx(7'h7E, n);
    @(posedge clk) rx <= 7'h00;
    wait_tx(7'h00, n);
    cyc(200);
  endtask

  task automatic t_txcol();
    int n;
    @(posedge clk) rx <= 7'h01;
    wait_tx(7'h7E, n);
    @(posedge clk) col <= 7'h09;
    wait_tx(7'h7F, n);
    chk_bit(ocol_oe, 1'b1);
    cyc(20);
    @(posedge clk)
    begin
      col <= 7'h08;
      rx <= 7'h00;
    end
    n = 21;
    while (tx_en === 7'h7F && n < 3000)
    begin
      cyc(1);
      n++;
    end
    chk_min(n, 960);
    chk_vec(tx_en, 7'h77);
    cyc(1);
    chk_bit(scol_oe, 1'b1);
    chk_bit(ocol_oe, 1'b0);
    @(posedge clk) col <= 7'h00;
    wait_tx(7'h00, n);
    cyc(200);
  endtask

  initial
  begin
    cyc(2);
    chk_vec(tx_en, 7'h00);
    chk_bit(chain_out, 1'b0);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(6);
    chk_bit(chain_out, 1'b1);
    chk_vec({4'h0, act_out, scol_out, ocol_out}, 7'h00);
    t_source();
    t_priority();
    t_chain_low();
    t_jabber();
    t_txcol();
    results();
  end
endmodule
